// [hdl/rx_desc_pkg.sv]
// Package: register map, field layout and fetch carrier of the receive descriptor queues
package rx_desc_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_Q1_CTRL    = 12'h00d4;
  localparam logic [11:0] OFS_Q2_CTRL    = 12'h00d8;
  localparam logic [11:0] OFS_UPPER_BASE = 12'h00dc;
  localparam logic [11:0] OFS_Q1_BASE    = 12'h00e0;
  localparam logic [11:0] OFS_Q2_BASE    = 12'h00e4;
  localparam logic [11:0] OFS_Q1_INDICES = 12'h00e8;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h0100;
  localparam logic [11:0] OFS_IRQ_MASK   = 12'h0104;
  localparam logic [11:0] OFS_Q2_INDICES = 12'h0108;
  // Shared queue control field positions
  localparam int BIT_VARIABLE_SIZE = 13;
  localparam int BIT_WIDE_BUFFER   = 12;
  localparam int BIT_WIDE_QUEUE    = 11;
  localparam int POS_STRIDE        = 8;
  localparam int BIT_Q1_WR_EN      = 7;
  localparam int BIT_Q2_WR_EN      = 6;
  localparam int BIT_Q1_DEPTH      = 14;
  // Queue 2 control field positions
  localparam int POS_Q2_LENGTH     = 16;
  localparam int BIT_Q2_DEPTH      = 14;
  // Index register field positions
  localparam int POS_FETCH_INDEX   = 16;
  // Interrupt status bits
  localparam int IRQ_Q2_LOW_WATER  = 0;
  localparam int IRQ_Q1_ROLLBACK   = 1;
  localparam int IRQ_Q2_ROLLBACK   = 2;
  localparam int IRQ_BITS          = 3;
  // Depth limits and widths
  localparam int INDEX_WIDTH       = 11;
  localparam logic [10:0] MASK_SMALL = 11'h00ff;
  localparam logic [10:0] MASK_LARGE = 11'h07ff;
  localparam logic [2:0]  STRIDE_MAX = 3'h5;
  // Values after reset
  localparam logic [31:0] RST_REG    = 32'h0000_0000;
  localparam logic [10:0] RST_INDEX  = 11'h000;
  // Descriptor fetch request to the bus master
  typedef struct packed {
    logic [63:0] addr;
    logic        wide;
    logic        queue;
  } fetch_req_t;
endpackage

// [hdl/desc_addr_calc.sv]
// Descriptor address former: base plus index times effective stride
`timescale 1ns/100ps
module desc_addr_calc
  import rx_desc_pkg::*;
(
  input  wire logic [23:0] lowerBase,
  input  wire logic [31:0] upperBase,
  input  wire logic [10:0] index,
  input  wire logic [2:0]  strideCode,
  input  wire logic        wideBuffer,
  input  wire logic        wideQueue,
  output logic      [63:0] addr
);
  logic [2:0]  code;
  logic [3:0]  shift;
  logic [31:0] offset;

  // Reserved stride codes clamp to the largest legal stride
  always_comb begin
    code  = (strideCode > STRIDE_MAX) ? STRIDE_MAX : strideCode;
    shift = 4'(code) + 4'h2;
    if (wideBuffer && shift < 4'h3) begin
      shift = 4'h3; // Eight-byte descriptor wider than the stride
    end
    offset = 32'(index) << shift;
    addr[31:0]  = {lowerBase, 8'h00} + offset;
    addr[63:32] = wideQueue ? upperBase : 32'h0000_0000;
  end
endmodule // desc_addr_calc

// [hdl/low_water_compare.sv]
// Available descriptor count compared against the low-water level
`timescale 1ns/100ps
module low_water_compare
  import rx_desc_pkg::*;
(
  input  wire logic [10:0] postIndex,
  input  wire logic [10:0] fetchIndex,
  input  wire logic [10:0] depthMask,
  input  wire logic [7:0]  level,
  input  wire logic        variableSize,
  output logic             below
);
  logic [10:0] avail;

  // Difference taken modulo the queue depth
  always_comb begin
    avail = (postIndex - fetchIndex) & depthMask;
    below = !variableSize && (avail < 11'(level));
  end
endmodule // low_water_compare

// [hdl/rx_queue_regs.sv]
// Receive descriptor queue registers, index tracking and descriptor fetch control
`timescale 1ns/100ps
module rx_queue_regs
  import rx_desc_pkg::*;
#(
  parameter int INDEX_W = INDEX_WIDTH
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [11:0] regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  input  wire logic        rxDmaEnable,
  input  wire logic        fetchDone,
  input  wire logic        frameStart,
  input  wire logic        frameStartQueue,
  input  wire logic        frameBad,
  input  wire logic        frameBadQueue,
  output fetch_req_t       fetchReq,
  output logic             fetchValid,
  output logic             irq
);
  typedef enum logic [0:0] {FETCH_IDLE, FETCH_WAIT} fetch_state_t;

  // Index logic is sized for eleven-bit indices only
  if (INDEX_W != INDEX_WIDTH) begin : g_width_check
    $error("rx_queue_regs supports only eleven-bit indices");
  end

  logic [31:0]         queueCtrl;
  logic [15:0]         q2BufferByteLength;
  logic                q2DepthSelect;
  logic [7:0]          q2LowWaterLevel;
  logic [31:0]         queueUpperBaseBits;
  logic [23:0]         q1LowerBaseBits;
  logic [23:0]         q2LowerBaseBits;
  logic [10:0]         q1FetchIndex;
  logic [10:0]         q1PostIndex;
  logic [10:0]         q2FetchIndex;
  logic [10:0]         q2PostIndex;
  logic [10:0]         q1FrameMark;
  logic [10:0]         q2FrameMark;
  logic [IRQ_BITS-1:0] irqStatus;
  logic [IRQ_BITS-1:0] irqMask;
  logic [IRQ_BITS-1:0] irqSet;
  fetch_state_t        state;
  logic                variableSize;
  logic                queueWideAddrEnable;
  logic                q1FetchIndexWrEn;
  logic                q2FetchIndexWrEn;
  logic [10:0]         q1Mask;
  logic [10:0]         q2Mask;
  logic                q1Empty;
  logic                q2Empty;
  logic                pickQ2;
  logic [10:0]         pickIndex;
  logic [23:0]         pickBase;
  logic [63:0]         pickAddr;
  logic                q2LowWaterIrq;
  logic                wrQ1Idx;
  logic                wrQ2Idx;
  logic                doneQ1;
  logic                doneQ2;
  logic                badQ1;
  logic                badQ2;

  // Control fields from the shared control register; queue 2 depth from its own register
  assign variableSize        = queueCtrl[BIT_VARIABLE_SIZE];
  assign queueWideAddrEnable = queueCtrl[BIT_WIDE_QUEUE];
  assign q1FetchIndexWrEn    = queueCtrl[BIT_Q1_WR_EN];
  assign q2FetchIndexWrEn    = queueCtrl[BIT_Q2_WR_EN];
  assign q1Mask = queueCtrl[BIT_Q1_DEPTH] ? MASK_LARGE : MASK_SMALL;
  assign q2Mask = q2DepthSelect ? MASK_LARGE : MASK_SMALL;

  // Empty when consumer reaches producer within the queue depth
  assign q1Empty = ((q1FetchIndex ^ q1PostIndex) & q1Mask) == 11'h000;
  assign q2Empty = ((q2FetchIndex ^ q2PostIndex) & q2Mask) == 11'h000;
  assign pickQ2    = q1Empty;
  assign pickIndex = pickQ2 ? q2FetchIndex : q1FetchIndex;
  assign pickBase  = pickQ2 ? q2LowerBaseBits : q1LowerBaseBits;

  // Index register writes and hardware index events decoded per queue
  assign wrQ1Idx = regWr && regAddr == OFS_Q1_INDICES;
  assign wrQ2Idx = regWr && regAddr == OFS_Q2_INDICES;
  assign doneQ1  = state == FETCH_WAIT && fetchDone && !fetchReq.queue;
  assign doneQ2  = state == FETCH_WAIT && fetchDone && fetchReq.queue;
  assign badQ1   = frameBad && !frameBadQueue;
  assign badQ2   = frameBad && frameBadQueue;

  desc_addr_calc u_addr (
    .lowerBase  (pickBase),
    .upperBase  (queueUpperBaseBits),
    .index      (pickIndex),
    .strideCode (queueCtrl[POS_STRIDE +: 3]),
    .wideBuffer (queueCtrl[BIT_WIDE_BUFFER]),
    .wideQueue  (queueWideAddrEnable),
    .addr       (pickAddr)
  );

  low_water_compare u_low (
    .postIndex    (q2PostIndex),
    .fetchIndex   (q2FetchIndex),
    .depthMask    (q2Mask),
    .level        (q2LowWaterLevel),
    .variableSize (variableSize),
    .below        (q2LowWaterIrq)
  );

  // Control and base registers, software writes only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      queueCtrl          <= RST_REG;
      q2BufferByteLength <= RST_REG[15:0];
      q2DepthSelect      <= 1'b0;
      q2LowWaterLevel    <= RST_REG[7:0];
      queueUpperBaseBits <= RST_REG;
      q1LowerBaseBits    <= RST_REG[23:0];
      q2LowerBaseBits    <= RST_REG[23:0];
    end else if (regWr) begin
      unique case (regAddr)
        OFS_Q1_CTRL: begin
          queueCtrl <= regWrData & 32'h0000_7fc0;
        end
        OFS_Q2_CTRL: begin
          q2BufferByteLength <= regWrData[POS_Q2_LENGTH +: 16];
          q2DepthSelect      <= regWrData[BIT_Q2_DEPTH];
          q2LowWaterLevel    <= regWrData[7:0];
        end
        OFS_UPPER_BASE: begin
          queueUpperBaseBits <= regWrData;
        end
        OFS_Q1_BASE: begin
          q1LowerBaseBits <= regWrData[31:8];
        end
        OFS_Q2_BASE: begin
          q2LowerBaseBits <= regWrData[31:8];
        end
        default: begin
        end
      endcase
    end
  end

  // Producer indices, owned by the host
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q1PostIndex <= RST_INDEX;
      q2PostIndex <= RST_INDEX;
    end else begin
      if (wrQ1Idx) begin
        q1PostIndex <= regWrData[10:0];
      end
      if (wrQ2Idx) begin
        q2PostIndex <= regWrData[10:0];
      end
    end
  end

  // Frame start marks where rollback returns to
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q1FrameMark <= RST_INDEX;
      q2FrameMark <= RST_INDEX;
    end else if (frameStart) begin
      if (frameStartQueue) begin
        q2FrameMark <= q2FetchIndex;
      end else begin
        q1FrameMark <= q1FetchIndex;
      end
    end
  end

  // Consumer indices: rollback beats fetch, fetch beats software
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q1FetchIndex <= RST_INDEX;
      q2FetchIndex <= RST_INDEX;
    end else begin
      if (badQ1) begin
        q1FetchIndex <= q1FrameMark;
      end else if (doneQ1) begin
        q1FetchIndex <= (q1FetchIndex + 11'h001) & q1Mask;
      end else if (wrQ1Idx && q1FetchIndexWrEn) begin
        q1FetchIndex <= regWrData[POS_FETCH_INDEX +: 11];
      end
      if (badQ2) begin
        q2FetchIndex <= q2FrameMark;
      end else if (doneQ2) begin
        q2FetchIndex <= (q2FetchIndex + 11'h001) & q2Mask;
      end else if (wrQ2Idx && q2FetchIndexWrEn) begin
        q2FetchIndex <= regWrData[POS_FETCH_INDEX +: 11];
      end
    end
  end

  // One outstanding fetch; queue 1 served first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state      <= FETCH_IDLE;
      fetchValid <= 1'b0;
      fetchReq   <= '0;
    end else begin
      unique case (state)
        FETCH_IDLE: begin
          if (rxDmaEnable && !frameBad && !(q1Empty && q2Empty)) begin
            state          <= FETCH_WAIT;
            fetchValid     <= 1'b1;
            fetchReq.addr  <= pickAddr;
            fetchReq.wide  <= queueWideAddrEnable;
            fetchReq.queue <= pickQ2;
          end
        end
        FETCH_WAIT: begin
          if (fetchDone || frameBad) begin
            state      <= FETCH_IDLE;
            fetchValid <= 1'b0;
          end
        end
      endcase
    end
  end

  // Sticky events; a new event wins over a same-cycle clear
  assign irqSet = {badQ2, badQ1, q2LowWaterIrq};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus <= '0;
      irqMask   <= '0;
      irq       <= 1'b0;
    end else begin
      if (regWr && regAddr == OFS_IRQ_STATUS) begin
        irqStatus <= (irqStatus & ~regWrData[IRQ_BITS-1:0]) | irqSet;
      end else begin
        irqStatus <= irqStatus | irqSet;
      end
      if (regWr && regAddr == OFS_IRQ_MASK) begin
        irqMask <= regWrData[IRQ_BITS-1:0];
      end
      irq <= |(irqStatus & irqMask);
    end
  end

  // Read data one cycle after the strobe; zero otherwise and for holes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= RST_REG;
    end else if (regRd) begin
      unique case (regAddr)
        OFS_Q1_CTRL:    regRdData <= queueCtrl;
        OFS_Q2_CTRL:    regRdData <= {q2BufferByteLength, 1'b0, q2DepthSelect,
                                      6'h00, q2LowWaterLevel};
        OFS_UPPER_BASE: regRdData <= queueUpperBaseBits;
        OFS_Q1_BASE:    regRdData <= {q1LowerBaseBits, 8'h00};
        OFS_Q2_BASE:    regRdData <= {q2LowerBaseBits, 8'h00};
        OFS_Q1_INDICES: regRdData <= {5'h00, q1FetchIndex, 5'h00, q1PostIndex};
        OFS_Q2_INDICES: regRdData <= {5'h00, q2FetchIndex, 5'h00, q2PostIndex};
        OFS_IRQ_STATUS: regRdData <= {29'h000_0000, irqStatus};
        OFS_IRQ_MASK:   regRdData <= {29'h000_0000, irqMask};
        default:        regRdData <= RST_REG;
      endcase
    end else begin
      regRdData <= RST_REG;
    end
  end

  // Checks next to the logic they guard
  chk_empty_no_fetch: assert property (@(posedge clk) disable iff (!rstn)
    state == FETCH_IDLE && q1Empty && q2Empty |=> !fetchValid)
    else $error("fetch issued from empty queues");
  chk_fetch_has_work: assert property (@(posedge clk) disable iff (!rstn)
    $rose(fetchValid) |-> !($past(q1Empty) && $past(q2Empty)))
    else $error("fetch beyond producer index");
  chk_consumer_protect: assert property (@(posedge clk) disable iff (!rstn)
    wrQ1Idx && !q1FetchIndexWrEn && !badQ1 && !doneQ1 |=> $stable(q1FetchIndex))
    else $error("protected consumer index changed");
  chk_consumer_write: assert property (@(posedge clk) disable iff (!rstn)
    wrQ1Idx && q1FetchIndexWrEn && !badQ1 && !doneQ1
      |=> q1FetchIndex == $past(regWrData[26:16]))
    else $error("enabled consumer write lost");
  chk_bad_rollback: assert property (@(posedge clk) disable iff (!rstn)
    badQ2 |=> q2FetchIndex == $past(q2FrameMark))
    else $error("consumer not rolled back");
  chk_small_wrap: assert property (@(posedge clk) disable iff (!rstn)
    doneQ2 && !badQ2 && !q2DepthSelect && q2FetchIndex == 11'h0ff |=> q2FetchIndex == 11'h000)
    else $error("queue two did not wrap at 256");
  chk_low_water_set: assert property (@(posedge clk) disable iff (!rstn)
    q2LowWaterIrq |=> irqStatus[IRQ_Q2_LOW_WATER])
    else $error("low-water event not latched");
  chk_variable_quiet: assert property (@(posedge clk) disable iff (!rstn)
    variableSize |-> !q2LowWaterIrq)
    else $error("low-water active in variable mode");
  chk_upper_bits: assert property (@(posedge clk) disable iff (!rstn)
    $rose(fetchValid) |-> fetchReq.addr[63:32] ==
      ($past(queueWideAddrEnable) ? $past(queueUpperBaseBits) : 32'h0000_0000))
    else $error("upper address bits wrong");
  chk_irq_output: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> irq == |($past(irqStatus) & $past(irqMask)))
    else $error("interrupt output mismatch");

  // Fetch handshake: request held steady until the bus master answers or a bad frame drops it
  chk_hold_request: assert property (@(posedge clk) disable iff (!rstn)
    fetchValid && !fetchDone && !frameBad |=> fetchValid && $stable(fetchReq))
    else $error("fetch request changed while outstanding");
  chk_wide_cycles: assert property (@(posedge clk) disable iff (!rstn)
    $rose(fetchValid) |-> fetchReq.wide == $past(queueWideAddrEnable))
    else $error("wide cycle flag wrong");

  // Consumer index ownership: hardware steps it, software only when allowed
  chk_fetch_advance: assert property (@(posedge clk) disable iff (!rstn)
    doneQ1 && !badQ1 && q1FetchIndex < 11'h0ff
      |=> q1FetchIndex == $past(q1FetchIndex) + 11'h001)
    else $error("consumer did not advance after fetch");
  chk_q1_rollback: assert property (@(posedge clk) disable iff (!rstn)
    badQ1 |=> q1FetchIndex == $past(q1FrameMark))
    else $error("queue one consumer not rolled back");
  chk_q2_protect: assert property (@(posedge clk) disable iff (!rstn)
    wrQ2Idx && !q2FetchIndexWrEn && !badQ2 && !doneQ2 |=> $stable(q2FetchIndex))
    else $error("protected queue two consumer changed");

  // An empty queue always has fewer buffers than a nonzero level
  chk_low_water_empty: assert property (@(posedge clk) disable iff (!rstn)
    !variableSize && q2Empty && q2LowWaterLevel != 8'h00 |-> q2LowWaterIrq)
    else $error("empty queue two did not flag low water");
  chk_read_idle: assert property (@(posedge clk) disable iff (!rstn)
    !regRd |=> regRdData == 32'h0000_0000)
    else $error("read data not zero outside a read");
endmodule // rx_queue_regs

// [test/fetch_responder.sv]
// Host memory model that answers descriptor fetches promptly or slowly
`timescale 1ns/100ps
module fetch_responder
  import rx_desc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic fetchValid,
  input  wire logic slow,
  output logic      fetchDone
);
  logic [2:0] waitCount;

  // One done pulse per fetch; the pulse cycle drops back to idle so no double answer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitCount <= 3'h0;
      fetchDone <= 1'b0;
    end else if (fetchValid && !fetchDone) begin
      fetchDone <= (waitCount >= (slow ? 3'h4 : 3'h0));
      waitCount <= waitCount + 3'h1;
    end else begin
      fetchDone <= 1'b0;
      waitCount <= 3'h0;
    end
  end
endmodule // fetch_responder

// [test/rx_queue_regs_tb.sv]
// Self-checking bench for the receive descriptor queue registers
`timescale 1ns/100ps
module rx_queue_regs_tb
  import rx_desc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h0000_0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdData;
  logic        rxDmaEnable = 1'b0;
  logic        fetchDone;
  logic        frameStart = 1'b0;
  logic        frameStartQueue = 1'b0;
  logic        frameBad = 1'b0;
  logic        frameBadQueue = 1'b0;
  fetch_req_t  fetchReq;
  logic        fetchValid;
  logic        irq;
  logic        slow = 1'b0;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          checks = 0;
  int          k;
  logic [11:0] regList [9] = '{OFS_Q1_CTRL, OFS_Q2_CTRL, OFS_UPPER_BASE, OFS_Q1_BASE,
    OFS_Q2_BASE, OFS_Q1_INDICES, OFS_IRQ_STATUS, OFS_IRQ_MASK, OFS_Q2_INDICES};

  // 25 MHz clock
  always #20 clk = ~clk;

  rx_queue_regs i_rx_queue_regs (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .rxDmaEnable(rxDmaEnable), .fetchDone(fetchDone), .frameStart(frameStart),
    .frameStartQueue(frameStartQueue), .frameBad(frameBad),
    .frameBadQueue(frameBadQueue), .fetchReq(fetchReq), .fetchValid(fetchValid),
    .irq(irq));
  fetch_responder i_fetch_responder (.clk(clk), .rstn(rstn), .fetchValid(fetchValid),
    .slow(slow), .fetchDone(fetchDone));

  // Register bus cycles, one strobe cycle each
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    v = regRdData;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    rd(a, d);
    chk({32'h0000_0000, d}, {32'h0000_0000, exp});
  endtask
  // Bounded wait for the next descriptor fetch
  task automatic wait_fetch();
    k = 0;
    while (fetchValid !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({63'h0, fetchValid}, 64'h1);
  endtask
  // One-cycle frame event for the chosen queue
  task automatic frame_event(input logic bad, input logic q);
    @(posedge clk);
    frameStart <= !bad;
    frameStartQueue <= q;
    frameBad <= bad;
    frameBadQueue <= q;
    @(posedge clk);
    frameStart <= 1'b0;
    frameBad <= 1'b0;
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog: whole sequence needs well under a thousand cycles
  initial begin
    #(40 * 5000);
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    foreach (regList[i]) rdchk(regList[i], 32'h0000_0000);
    $display("Test reset values done");
    wr(OFS_Q2_CTRL, 32'hfffc_ffff);
    rdchk(OFS_Q2_CTRL, 32'hfffc_40ff);
    wr(OFS_Q2_CTRL, 32'h0000_0000);
    wr(OFS_UPPER_BASE, 32'habcd_0123);
    rdchk(OFS_UPPER_BASE, 32'habcd_0123);
    wr(OFS_Q1_BASE, 32'h1234_5600);
    rdchk(OFS_Q1_BASE, 32'h1234_5600);
    wr(OFS_Q2_BASE, 32'h0000_8100);
    rdchk(OFS_Q2_BASE, 32'h0000_8100);
    wr(12'h0f0, 32'hffff_ffff);
    rdchk(12'h0f0, 32'h0000_0000);
    // Consumer field only moves while its write enable is set
    wr(OFS_Q1_INDICES, 32'h0003_0000);
    rdchk(OFS_Q1_INDICES, 32'h0000_0000);
    wr(OFS_Q1_CTRL, 32'h0000_0080);
    wr(OFS_Q1_INDICES, 32'h0003_0003);
    rdchk(OFS_Q1_INDICES, 32'h0003_0003);
    wr(OFS_Q1_CTRL, 32'h0000_0000);
    wr(OFS_Q1_INDICES, 32'h0000_0000);
    rdchk(OFS_Q1_INDICES, 32'h0003_0000);
    wr(OFS_Q1_CTRL, 32'h0000_0080);
    wr(OFS_Q1_INDICES, 32'h0000_0000);
    $display("Test register access done");
    // Legal stride codes 0 to 5, alternating narrow and wide queue addressing
    @(posedge clk);
    rxDmaEnable <= 1'b1;
    for (logic [3:0] c = 4'h0; c < 4'h6; c++) begin
      wr(OFS_Q1_CTRL, {20'h0_0000, c[0], c[2:0], 8'h00});
      slow <= c[1];
      wr(OFS_Q1_INDICES, 32'(c) + 32'h0000_0001);
      wait_fetch();
      chk(fetchReq.addr, {c[0] ? 32'habcd_0123 : 32'h0000_0000,
        32'h1234_5600 + (32'(c) << (c + 4'h2))});
      chk({62'h0, fetchReq.wide, fetchReq.queue}, {62'h0, c[0], 1'b0});
      repeat (8) @(posedge clk);
      #1;
      chk({63'h0, fetchValid}, 64'h0);
      rdchk(OFS_Q1_INDICES, {5'h00, 11'(c + 4'h1), 5'h00, 11'(c + 4'h1)});
    end
    $display("Test fetch addressing done");
    @(posedge clk);
    rxDmaEnable <= 1'b0;
    // Start from a clean status so the level event is seen fresh
    wr(OFS_IRQ_STATUS, 32'h0000_0007);
    rdchk(OFS_IRQ_STATUS, 32'h0000_0000);
    wr(OFS_Q2_INDICES, 32'h0000_0002);
    wr(OFS_Q2_CTRL, 32'h0000_0003);
    wr(OFS_IRQ_STATUS, 32'h0000_0007);
    rdchk(OFS_IRQ_STATUS, 32'h0000_0001);
    wr(OFS_Q1_CTRL, 32'h0000_2000);
    wr(OFS_IRQ_STATUS, 32'h0000_0007);
    rdchk(OFS_IRQ_STATUS, 32'h0000_0000);
    wr(OFS_Q2_CTRL, 32'h0000_0002);
    wr(OFS_Q1_CTRL, 32'h0000_0000);
    wr(OFS_IRQ_STATUS, 32'h0000_0007);
    rdchk(OFS_IRQ_STATUS, 32'h0000_0000);
    // Index 256 wraps to empty in a 256-entry queue but not in a 2048-entry one
    wr(OFS_Q2_CTRL, 32'h0000_0000);
    wr(OFS_Q2_INDICES, 32'h0000_0100);
    @(posedge clk);
    rxDmaEnable <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk({63'h0, fetchValid}, 64'h0);
    wr(OFS_Q2_CTRL, 32'h0000_4000);
    wait_fetch();
    chk({fetchReq.addr[62:0], fetchReq.queue}, {63'h0000_8100, 1'b1});
    @(posedge clk);
    rxDmaEnable <= 1'b0;
    repeat (8) @(posedge clk);
    // Empty queue 2 again so it stays out of the queue 1 tests
    wr(OFS_Q2_INDICES, 32'h0000_0001);
    rdchk(OFS_Q2_INDICES, 32'h0001_0001);
    $display("Test low water and depth done");
    // Bad frame rolls queue 1 back to where the frame began
    // Buffers are counted as the producer the bench posted minus the consumer
    wr(OFS_IRQ_STATUS, 32'h0000_0007);
    frame_event(1'b0, 1'b0);
    wr(OFS_Q1_INDICES, 32'h0000_0009);
    @(posedge clk);
    rxDmaEnable <= 1'b1;
    repeat (40) @(posedge clk);
    rxDmaEnable <= 1'b0;
    repeat (8) @(posedge clk);
    rdchk(OFS_Q1_INDICES, 32'h0009_0009);
    frame_event(1'b1, 1'b0);
    rdchk(OFS_Q1_INDICES, 32'h0006_0009);
    rdchk(OFS_IRQ_STATUS, 32'h0000_0002);
    chk({63'h0, irq}, 64'h0);
    wr(OFS_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge clk);
    #1;
    chk({63'h0, irq}, 64'h1);
    wr(OFS_IRQ_STATUS, 32'h0000_0002);
    repeat (2) @(posedge clk);
    #1;
    chk({63'h0, irq}, 64'h0);
    $display("Test rollback and interrupt done");
    // Queue 2 wraps at 256 entries, then a bad frame rolls it back
    wr(OFS_Q1_INDICES, 32'h0000_0006);
    wr(OFS_Q1_CTRL, 32'h0000_0040);
    wr(OFS_Q2_CTRL, 32'h0000_0000);
    wr(OFS_Q2_INDICES, 32'h00fe_0001);
    wr(OFS_Q1_CTRL, 32'h0000_0000);
    frame_event(1'b0, 1'b1);
    @(posedge clk);
    rxDmaEnable <= 1'b1;
    repeat (20) @(posedge clk);
    rxDmaEnable <= 1'b0;
    repeat (8) @(posedge clk);
    rdchk(OFS_Q2_INDICES, 32'h0001_0001);
    frame_event(1'b1, 1'b1);
    rdchk(OFS_Q2_INDICES, 32'h00fe_0001);
    rdchk(OFS_IRQ_STATUS, 32'h0000_0004);
    $display("Test queue two wrap and rollback done");
    stop_test();
  end
endmodule // rx_queue_regs_tb
